//--- logic/asc_ctrl.sv
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
// Overview of operation
// - Acquisition delay 0..20 conversion clocks by select
// - Trigger starts only in mode 1011 enabled
// - Accepted trigger sets go, clears timer
// - Disabled converter ignores trigger, timer still cleared
// - Result split into high and low bytes
// - Unimplemented control bits read as zero
module asc_ctrl (
   input  wire logic                  clk,                // System clock, 25 MHz
   input  wire logic                  rstn,               // Async reset, active low
   input  wire asc_pkg::asc_bus_req_t bus,                // Register access request
   output logic [7:0]                 rdata,              // Read data, cycle after read
   input  wire logic                  special_event_trig, // Compare unit event pulse
   input  wire logic [3:0]            compare_mode_field, // Compare unit mode
   input  wire logic                  rc_clk_in,          // Dedicated RC oscillator
   input  wire logic [9:0]            core_result,        // Converted code from core
   input  wire logic                  core_done,          // Core finished, one pulse
   output asc_pkg::asc_core_out_t     core,               // Controls to analog core
   output logic [5:0]                 ref_config,         // Reference and port config
   output logic                       timer_clear,        // Clear event timer, pulse
   output logic                       irq                 // Interrupt, level
);
   import asc_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      asc_state_t state;
      logic [3:0] chan;
      logic       go;
      logic       enable;
      logic [5:0] ref_cfg;
      logic       justify;
      logic [2:0] acq_sel;
      logic [2:0] clk_sel;
      logic [7:0] res_hi;
      logic [7:0] res_lo;
      logic [2:0] irq_status;
      logic [2:0] irq_enable;
      logic [4:0] cnt;
      logic [7:0] rdata;
      logic       timer_clear;
      logic       irq;
   } asc_ctrl_st_t;

   asc_ctrl_st_t st_reg;
   asc_ctrl_st_t st_next;

   logic       tad_tick;
   logic       tad_run;
   logic       trig_match;
   logic       trig_start;
   logic       sw_start;
   logic       start;
   logic       finish;
   logic [2:0] irq_set;
   logic [2:0] irq_clr;
   logic [7:0] rd_val;

   // ------------------------------------------------------------
   // Conversion clock
   // ------------------------------------------------------------
   assign tad_run = (st_reg.state == ST_ACQ) || (st_reg.state == ST_CONV);

   asc_tad_gen #(
      .DIV_W (7)
   ) u_tad_gen (
      .clk       (clk),
      .rstn      (rstn),
      .run       (tad_run),
      .clk_sel   (st_reg.clk_sel),
      .rc_clk_in (rc_clk_in),
      .tick      (tad_tick)
   );

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      st_next             = st_reg;
      st_next.timer_clear = 1'b0;
      irq_set             = '0;
      irq_clr             = '0;
      finish              = 1'b0;
      rd_val              = 8'h00;

      // Start sources
      trig_match = special_event_trig && (compare_mode_field == TRIG_MODE);
      trig_start = trig_match && st_reg.enable && (st_reg.state == ST_IDLE);
      sw_start   = bus.wr && (bus.addr == OFS_CHAN_START) && bus.wdata[POS_GO]
                   && bus.wdata[POS_ENABLE] && (st_reg.state == ST_IDLE);
      start      = trig_start || sw_start;

      if (trig_match) begin
         st_next.timer_clear = 1'b1;
         if (st_reg.enable) begin
            irq_set[POS_IRQ_TRIG] = 1'b1;
         end else begin
            irq_set[POS_IRQ_IGNORED] = 1'b1;
         end
      end

      // Register writes
      if (bus.wr) begin
         if (bus.addr == OFS_CHAN_START) begin
            st_next.chan   = bus.wdata[POS_CHAN +: 4];
            st_next.enable = bus.wdata[POS_ENABLE];
         end else if (bus.addr == OFS_REF_PORT) begin
            st_next.ref_cfg = bus.wdata[5:0];
         end else if (bus.addr == OFS_TIMING) begin
            st_next.justify = bus.wdata[POS_JUSTIFY];
            st_next.acq_sel = bus.wdata[POS_ACQ +: 3];
            st_next.clk_sel = bus.wdata[POS_CLKSEL +: 3];
         end else if (bus.addr == OFS_RES_HIGH) begin
            st_next.res_hi = bus.wdata;
         end else if (bus.addr == OFS_RES_LOW) begin
            st_next.res_lo = bus.wdata;
         end else if (bus.addr == OFS_IRQ_CLEAR) begin
            irq_clr = bus.wdata[2:0];
         end else if (bus.addr == OFS_IRQ_ENABLE) begin
            st_next.irq_enable = bus.wdata[2:0];
         end
      end

      // Sequencer
      case (st_reg.state)
         ST_IDLE: begin
            st_next.cnt = '0;
            if (start) begin
               st_next.go = 1'b1;
               if (CONV_DIV[st_reg.clk_sel] == '0) begin
                  st_next.state = ST_RC_WAIT;
               end else if (ACQ_TADS[st_reg.acq_sel] == '0) begin
                  st_next.state = ST_CONV;
               end else begin
                  st_next.state = ST_ACQ;
               end
            end
         end
         ST_RC_WAIT: begin
            if (st_reg.cnt == 5'(INSTR_CYCLE_CLKS - 1)) begin
               st_next.cnt   = '0;
               st_next.state = (ACQ_TADS[st_reg.acq_sel] == '0) ? ST_CONV : ST_ACQ;
            end else begin
               st_next.cnt = st_reg.cnt + 5'h01;
            end
         end
         ST_ACQ: begin
            if (tad_tick) begin
               if (st_reg.cnt == ACQ_TADS[st_reg.acq_sel] - 5'h01) begin
                  st_next.cnt   = '0;
                  st_next.state = ST_CONV;
               end else begin
                  st_next.cnt = st_reg.cnt + 5'h01;
               end
            end
         end
         ST_CONV: begin
            if (core_done) begin
               finish        = 1'b1;
               st_next.state = ST_IDLE;
               st_next.go    = 1'b0;
               irq_set[POS_IRQ_DONE] = 1'b1;
               if (st_reg.justify) begin
                  st_next.res_hi = {6'h00, core_result[9:8]};
                  st_next.res_lo = core_result[7:0];
               end else begin
                  st_next.res_hi = core_result[9:2];
                  st_next.res_lo = {core_result[1:0], 6'h00};
               end
            end
         end
         default: begin
            st_next.state = ST_IDLE;
            st_next.go    = 1'b0;
         end
      endcase

      // Disabling the converter aborts a conversion in flight unless core_done ends it in the same cycle
      if (!st_next.enable && !finish) begin
         st_next.state = ST_IDLE;
         st_next.go    = 1'b0;
         st_next.cnt   = '0;
      end

      // Sticky status: a set in the same cycle beats the clear
      st_next.irq_status = (st_reg.irq_status & ~irq_clr) | irq_set;
      st_next.irq        = |(st_next.irq_status & st_next.irq_enable);

      // Register reads
      if (bus.addr == OFS_CHAN_START) begin
         rd_val = {2'b00, st_reg.chan, st_reg.go, st_reg.enable};
      end else if (bus.addr == OFS_REF_PORT) begin
         rd_val = {2'b00, st_reg.ref_cfg};
      end else if (bus.addr == OFS_TIMING) begin
         rd_val = {st_reg.justify, 1'b0, st_reg.acq_sel, st_reg.clk_sel};
      end else if (bus.addr == OFS_RES_HIGH) begin
         rd_val = st_reg.res_hi;
      end else if (bus.addr == OFS_RES_LOW) begin
         rd_val = st_reg.res_lo;
      end else if (bus.addr == OFS_IRQ_STATUS) begin
         rd_val = {5'h00, st_reg.irq_status};
      end else if (bus.addr == OFS_IRQ_ENABLE) begin
         rd_val = {5'h00, st_reg.irq_enable};
      end else begin
         rd_val = 8'h00;
      end
      st_next.rdata = bus.rd ? rd_val : 8'h00;
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_reg             <= '0;
         st_reg.state       <= ST_IDLE;
         st_reg.chan        <= RST_CHAN;
         st_reg.ref_cfg     <= RST_REF;
         st_reg.acq_sel     <= RST_ACQ;
         st_reg.clk_sel     <= RST_CLKSEL;
         st_reg.res_hi      <= RST_RESULT;
         st_reg.res_lo      <= RST_RESULT;
         st_reg.irq_status  <= RST_IRQ;
         st_reg.irq_enable  <= RST_IRQ;
      end else begin
         st_reg <= st_next;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign rdata         = st_reg.rdata;
   assign ref_config    = st_reg.ref_cfg;
   assign timer_clear   = st_reg.timer_clear;
   assign irq           = st_reg.irq;
   assign core.channel  = st_reg.chan;
   assign core.sample   = st_reg.state == ST_ACQ;
   assign core.convert  = st_reg.state == ST_CONV;
   // A tick registered in the last active cycle must not leak into idle
   assign core.tad_tick = tad_tick && tad_run;

endmodule

//--- logic/asc_pkg.sv
package asc_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS    = 40;
   localparam int unsigned INSTR_CYCLE_NS   = 160;
   localparam int unsigned INSTR_CYCLE_CLKS =
      ((INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
      ((INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // Acquisition delay in conversion clock periods, indexed by acq_delay_sel
   localparam logic [7:0][4:0] ACQ_TADS = {5'h14, 5'h10, 5'h0c, 5'h08,
                                           5'h06, 5'h04, 5'h02, 5'h00};
   // System clocks per conversion clock period, indexed by conv_clock_sel; 0 = RC
   localparam logic [7:0][6:0] CONV_DIV = {7'h00, 7'h40, 7'h10, 7'h04,
                                           7'h00, 7'h20, 7'h08, 7'h02};

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam int unsigned ADDR_W   = 3;
   localparam logic [2:0] OFS_CHAN_START = 3'h0;
   localparam logic [2:0] OFS_REF_PORT   = 3'h1;
   localparam logic [2:0] OFS_TIMING     = 3'h2;
   localparam logic [2:0] OFS_RES_HIGH   = 3'h3;
   localparam logic [2:0] OFS_RES_LOW    = 3'h4;
   localparam logic [2:0] OFS_IRQ_STATUS = 3'h5;
   localparam logic [2:0] OFS_IRQ_CLEAR  = 3'h6;
   localparam logic [2:0] OFS_IRQ_ENABLE = 3'h7;

   // channel_and_start_control fields
   localparam int unsigned POS_ENABLE = 0;
   localparam int unsigned POS_GO     = 1;
   localparam int unsigned POS_CHAN   = 2;
   // conversion_timing_control fields
   localparam int unsigned POS_CLKSEL = 0;
   localparam int unsigned POS_ACQ    = 3;
   localparam int unsigned POS_JUSTIFY = 7;
   // Interrupt status bits
   localparam int unsigned POS_IRQ_DONE    = 0;
   localparam int unsigned POS_IRQ_TRIG    = 1;
   localparam int unsigned POS_IRQ_IGNORED = 2;

   localparam logic [3:0] RST_CHAN    = 4'h0;
   localparam logic [5:0] RST_REF     = 6'h00;
   localparam logic [2:0] RST_ACQ     = 3'h0;
   localparam logic [2:0] RST_CLKSEL  = 3'h0;
   localparam logic [7:0] RST_RESULT  = 8'h00;
   localparam logic [2:0] RST_IRQ     = 3'h0;

   localparam logic [3:0] TRIG_MODE   = 4'hb;
   localparam int unsigned RESULT_W   = 10;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE    = 4'b0001,
      ST_RC_WAIT = 4'b0010,
      ST_ACQ     = 4'b0100,
      ST_CONV    = 4'b1000
   } asc_state_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0]        wdata;
      logic              wr;
      logic              rd;
   } asc_bus_req_t;

   typedef struct packed {
      logic [3:0] channel;
      logic       sample;
      logic       convert;
      logic       tad_tick;
   } asc_core_out_t;

endpackage

//--- logic/asc_tad_gen.sv
`timescale 1ns/100ps
module asc_tad_gen #(
   parameter int unsigned DIV_W = 7
) (
   input  wire logic             clk,       // System clock
   input  wire logic             rstn,      // Async reset, active low
   input  wire logic             run,       // Generate ticks while high
   input  wire logic [2:0]       clk_sel,   // conv_clock_sel
   input  wire logic             rc_clk_in, // dedicated_rc_clock pin
   output logic                  tick       // One pulse per conversion clock period
);
   import asc_pkg::*;

   typedef struct packed {
      logic [DIV_W-1:0] cnt;
      logic             tick;
      logic [2:0]       rc_sync;
      logic             rc_lvl;
   } asc_tad_st_t;

   asc_tad_st_t st_reg;
   asc_tad_st_t st_next;
   logic [DIV_W-1:0] div;
   logic             rc_stable;
   logic             rc_rise;

   always_comb begin
      div       = CONV_DIV[clk_sel][DIV_W-1:0];
      rc_stable = st_reg.rc_sync[1] == st_reg.rc_sync[2];
      rc_rise   = rc_stable && st_reg.rc_sync[2] && !st_reg.rc_lvl;
      st_next         = st_reg;
      st_next.rc_sync = {st_reg.rc_sync[1:0], rc_clk_in};
      st_next.tick    = 1'b0;
      if (rc_stable) begin
         st_next.rc_lvl = st_reg.rc_sync[2];
      end
      if (!run) begin
         st_next.cnt = '0;
      end else if (div == '0) begin
         st_next.tick = rc_rise;
      end else if (st_reg.cnt == div - 1'b1) begin
         st_next.cnt  = '0;
         st_next.tick = 1'b1;
      end else begin
         st_next.cnt = st_reg.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign tick = st_reg.tick;
endmodule

//--- sim/asc_core_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Analog core stand-in and free-running RC oscillator
// ------------------------------------------------------------
module asc_core_model #(
   parameter int unsigned CONV_TADS = 11 // Ticks per conversion
) (
   input  wire logic                   clk,    // System clock
   input  wire logic                   rstn,   // Async reset, active low
   input  wire asc_pkg::asc_core_out_t core,   // Controls from block
   input  wire logic [9:0]             code,   // Code to return
   output logic [9:0]                  result, // Converted code
   output logic                        done,   // Finish pulse
   output logic                        rc_clk  // RC oscillator
);
   import asc_pkg::*;
   int unsigned n_tick;

   initial rc_clk = 1'b0;
   always #95 rc_clk = ~rc_clk;

   // Result only valid with done; inverted otherwise
   assign result = done ? code : ~code;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         n_tick <= 0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (!core.convert || done) begin
            n_tick <= 0;
         end else if (core.tad_tick) begin
            n_tick <= n_tick + 1;
            if (n_tick + 1 == CONV_TADS) begin
               done <= 1'b1;
            end
         end
      end
   end
endmodule

//--- sim/asc_ctrl_monitor.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Port checker for the converter control block
// ------------------------------------------------------------
module asc_ctrl_monitor (
   input wire logic                  clk,                // Clock
   input wire logic                  rstn,               // Reset
   input wire asc_pkg::asc_bus_req_t bus,                // Bus request
   input wire logic [7:0]            rdata,              // Read data
   input wire logic                  special_event_trig, // Trigger
   input wire logic [3:0]            compare_mode_field, // Compare mode
   input wire logic                  rc_clk_in,          // RC clock
   input wire logic [9:0]            core_result,        // Core code
   input wire logic                  core_done,          // Core done
   input wire asc_pkg::asc_core_out_t core,              // Core controls
   input wire logic [5:0]            ref_config,         // Config bits
   input wire logic                  timer_clear,        // Timer clear
   input wire logic                  irq                 // Interrupt
);
   import asc_pkg::*;
   default clocking dc @(posedge clk); endclocking
   default disable iff (!rstn);
   wire acc = special_event_trig && compare_mode_field == TRIG_MODE;

   a_trig_clears_timer: assert property (acc |=> timer_clear)
      else $error("timer clear missing after trigger");
   a_no_stray_clear: assert property (!acc |=> !timer_clear)
      else $error("timer clear without trigger");
   a_tick_only_active: assert property (
      core.tad_tick |-> core.sample || core.convert)
      else $error("conversion tick while idle");
   a_acq_ticks_come: assert property (
      core.sample |-> ##[0:70] (core.tad_tick || !core.sample))
      else $error("no conversion tick during acquisition");
   a_done_ends_conv: assert property (
      core_done && core.convert |=> ##[0:1] !core.convert)
      else $error("conversion state outlives done");
   a_rdata_idle_zero: assert property (!bus.rd |=> rdata == 8'h00)
      else $error("read data outside read cycle");
   a_timing_gap_zero: assert property (
      bus.rd && bus.addr == OFS_TIMING |=> !rdata[6])
      else $error("unused timing bit reads one");
   a_chan_top_zero: assert property (
      bus.rd && bus.addr == OFS_CHAN_START |=> rdata[7:6] == 2'b00)
      else $error("unused channel bits read one");
endmodule

bind asc_ctrl asc_ctrl_monitor asc_ctrl_monitor_i (
   .clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata),
   .special_event_trig(special_event_trig), .compare_mode_field(compare_mode_field),
   .rc_clk_in(rc_clk_in), .core_result(core_result), .core_done(core_done),
   .core(core), .ref_config(ref_config), .timer_clear(timer_clear), .irq(irq)
);

//--- sim/asc_ctrl_tb.sv
`timescale 1ns/100ps
module asc_ctrl_tb;
   import asc_pkg::*;
   logic clk, rstn, trig, rc_clk, done, timer_clear, irq;
   logic [3:0] mode;
   logic [9:0] code, result, c;
   logic [7:0] rdata, d;
   logic [5:0] ref_config;
   asc_bus_req_t bus;
   asc_core_out_t core;
   int n_mismatch = 0;
   int n_checks = 0;
   int i, n_acq, gap, lat;
   int acq_tads[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
   int divs[8] = '{2, 8, 32, 0, 4, 16, 64, 0};

   asc_ctrl asc_ctrl_i (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata),
      .special_event_trig(trig), .compare_mode_field(mode), .rc_clk_in(rc_clk),
      .core_result(result), .core_done(done), .core(core), .ref_config(ref_config),
      .timer_clear(timer_clear), .irq(irq));
   asc_core_model asc_core_model_i (.clk(clk), .rstn(rstn), .core(core), .code(code),
      .result(result), .done(done), .rc_clk(rc_clk));

   initial clk = 1'b0;
   always #20 clk = ~clk;

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk);
      bus <= '{a, v, 1'b1, 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
      @(posedge clk);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      v = rdata;
   endtask
   task automatic pulse_trig(input logic [3:0] m);
      @(posedge clk);
      trig <= 1'b1;
      mode <= m;
      @(posedge clk);
      trig <= 1'b0;
      #1;
   endtask
   task automatic wait_done();
      int t;
      for (t = 0; t < 3000 && done !== 1'b1; t++) @(posedge clk);
      check(done, 1'b1);
   endtask
   // Software start; counts acquisition ticks, tick spacing, start latency
   task automatic run_conv(input logic [7:0] tim, input logic [9:0] val);
      int t;
      int last;
      n_acq = 0;
      gap = 0;
      lat = 0;
      last = 0;
      code <= val;
      wr_reg(OFS_TIMING, tim);
      wr_reg(OFS_CHAN_START, 8'h0b);
      for (t = 1; t < 3000 && done !== 1'b1; t++) begin
         @(posedge clk);
         #1;
         if (core.sample === 1'b1 && lat == 0) lat = t;
         if (core.sample === 1'b1 && core.tad_tick === 1'b1) n_acq++;
         if (core.convert === 1'b1 && core.tad_tick === 1'b1) begin
            if (last > 0 && gap == 0) gap = t - last;
            last = t;
         end
      end
      check(done, 1'b1);
   endtask

   initial begin
      #2_000_000;
      n_mismatch++;
      wrap_up();
   end

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      rstn = 1'b0;
      bus = '0;
      trig = 1'b0;
      mode = 4'h0;
      code = 10'h000;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      for (i = 0; i < 8; i++) begin
         rd_reg(3'(i), d);
         check(d, 8'h00);
      end
      wr_reg(OFS_TIMING, 8'hff);
      rd_reg(OFS_TIMING, d);
      check(d, 8'hbf);
      wr_reg(OFS_CHAN_START, 8'hfc);
      rd_reg(OFS_CHAN_START, d);
      check(d, 8'h3c);
      wr_reg(OFS_REF_PORT, 8'hff);
      rd_reg(OFS_REF_PORT, d);
      check(d, 8'h3f);
      check(ref_config, 6'h3f);
      $display("register test done");
      for (i = 0; i < 8; i++) begin
         c = 10'h2c5 ^ 10'(i * 37);
         run_conv({i[0], 1'b0, 3'(i), 3'h0}, c);
         check(n_acq, acq_tads[i]);
         rd_reg(OFS_RES_HIGH, d);
         check(d, i[0] ? {6'h00, c[9:8]} : c[9:2]);
         rd_reg(OFS_RES_LOW, d);
         check(d, i[0] ? c[7:0] : {c[1:0], 6'h00});
      end
      $display("acquisition test done");
      for (i = 0; i < 8; i++) begin
         run_conv({5'h01, 3'(i)}, 10'h155);
         check(lat > 2, divs[i] == 0);
         if (divs[i] != 0) check(gap, divs[i]);
      end
      $display("clock test done");
      wr_reg(OFS_TIMING, 8'h08);
      wr_reg(OFS_CHAN_START, 8'h09);
      for (i = 0; i < 16; i++) begin
         pulse_trig(4'(i));
         check(timer_clear, i == 11);
         rd_reg(OFS_CHAN_START, d);
         check(d, (i == 11) ? 8'h0b : 8'h09);
         check(core.channel, 4'h2);
         if (i == 11) wait_done();
      end
      wr_reg(OFS_CHAN_START, 8'h08);
      pulse_trig(4'hb);
      check(timer_clear, 1'b1);
      rd_reg(OFS_CHAN_START, d);
      check(d, 8'h08);
      wr_reg(OFS_CHAN_START, 8'h0b);
      wr_reg(OFS_CHAN_START, 8'h08);
      rd_reg(OFS_CHAN_START, d);
      check(d, 8'h08);
      check(core.sample | core.convert, 1'b0);
      wr_reg(OFS_RES_HIGH, 8'ha5);
      rd_reg(OFS_RES_HIGH, d);
      check(d, 8'ha5);
      rd_reg(OFS_IRQ_STATUS, d);
      check(d, 8'h07);
      check(irq, 1'b0);
      wr_reg(OFS_IRQ_ENABLE, 8'h04);
      rd_reg(OFS_IRQ_ENABLE, d);
      check(d, 8'h04);
      check(irq, 1'b1);
      wr_reg(OFS_IRQ_STATUS, 8'h00);
      wr_reg(OFS_IRQ_CLEAR, 8'h04);
      rd_reg(OFS_IRQ_STATUS, d);
      check(d, 8'h03);
      check(irq, 1'b0);
      rd_reg(OFS_IRQ_CLEAR, d);
      check(d, 8'h00);
      $display("trigger and interrupt test done");
      wrap_up();
   end
endmodule
